/* File: design/cio_core.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// execution unit for interrupt enable, halt, increment-and-skip and interrupt return
module cio_core
    import cio_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // program byte stream
    input  wire logic        prog_valid,
    input  wire logic [7:0]  prog_byte,
    output logic             prog_ready,
    output logic [14:0]      fetch_addr,
    // interrupt request pin and answer
    input  wire logic        irq_req,
    output logic             irq_ack,
    output logic             core_idle,
    output logic             irq_enabled,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);
    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        cio_state_e        st;
        logic [1:0]        cnt;
        logic [7:0]        op;
        logic [14:0]       pc;
        logic [7:0]        sp;
        logic [3:0]        prio;
        logic [3:0]        power;
        logic              carry;
        logic [2:0]        sc;
        logic [1:0]        isl;
        logic              mbank;
        logic              rbank;
        logic [7:0][3:0]   regs;
        logic [255:0][3:0] mem;
        logic              irq_m;
        logic              irq_s;
        logic              irq_busy;
        logic              irq_ack;
        logic              prog_ready;
        logic [7:0]        maddr;
        logic [31:0]       tick;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } cio_core_s;

    cio_core_s  q_reg;
    cio_core_s  q_next;
    logic [1:0] len;
    logic       take;
    logic       apb_acc;

    assign take    = prog_valid & q_reg.prog_ready;
    assign apb_acc = psel & penable & ~q_reg.pready;

    // length of instruction at stream head
    cio_len u_len (
        .first_byte (prog_byte),
        .len        (len)
    );

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic [4:0] sum4;
        logic [8:0] sum8;
        logic [7:0] a;
        logic [7:0] ptr;
        logic       serve;
        serve         = 1'b0;
        sum4          = '0;
        sum8          = '0;
        a             = '0;
        ptr           = {q_reg.regs[{PTR_PAIR, 1'b1}], q_reg.regs[{PTR_PAIR, 1'b0}]};
        q_next        = q_reg;
        q_next.irq_m  = irq_req;
        q_next.irq_s  = q_reg.irq_m;
        q_next.tick   = q_reg.tick + 32'h0000_0001; // RULE5
        q_next.pready = 1'b0;
        serve         = (q_reg.st == ST_FETCH) & q_reg.prio[GIE_BIT] & q_reg.irq_s & ~q_reg.irq_busy;
        q_next.irq_ack = serve & ~q_reg.power[IDLE_BIT]; // RULE2 RULE13
        if (q_next.irq_ack) begin
            q_next.irq_busy = 1'b1;
        end else if (!q_reg.irq_s) begin
            q_next.irq_busy = 1'b0;
        end
        // apb register access, answered one cycle into the access phase
        if (apb_acc) begin
            q_next.pready  = 1'b1;
            q_next.pslverr = 1'b0;
            q_next.prdata  = '0;
            unique case (paddr)
                OFS_PRIO: begin
                    q_next.prdata[3:0] = q_reg.prio;
                    if (pwrite) q_next.prio = pwdata[3:0];
                end
                OFS_POWER: begin
                    q_next.prdata[3:0] = q_reg.power;
                    if (pwrite) q_next.power = pwdata[3:0];
                end
                OFS_CORE: begin
                    q_next.prdata = {8'h00, q_reg.sp, 1'b0, q_reg.pc};
                    if (pwrite) begin
                        q_next.pc = pwdata[14:0];
                        q_next.sp = pwdata[23:16];
                    end
                end
                OFS_STATUS: begin
                    q_next.prdata[7:0] = {q_reg.carry, q_reg.sc, q_reg.isl, q_reg.mbank, q_reg.rbank};
                    if (pwrite) {q_next.carry, q_next.sc, q_next.isl, q_next.mbank, q_next.rbank} = pwdata[7:0];
                end
                OFS_MADDR: begin
                    q_next.prdata[7:0] = q_reg.maddr;
                    if (pwrite) q_next.maddr = pwdata[7:0];
                end
                OFS_MDATA: begin
                    q_next.prdata[3:0] = q_reg.mem[q_reg.maddr];
                    if (pwrite) q_next.mem[q_reg.maddr] = pwdata[3:0];
                end
                OFS_REGS: begin
                    q_next.prdata = q_reg.regs;
                    if (pwrite) q_next.regs = pwdata;
                end
                OFS_TICK: q_next.prdata = q_reg.tick;
                default:  q_next.pslverr = 1'b1;
            endcase
        end
        // a pending request wakes the halted core
        if (q_reg.irq_s && q_reg.power[IDLE_BIT]) begin
            q_next.power[IDLE_BIT] = 1'b0;
        end
        // instruction sequencing; hardware updates override same-cycle software writes
        unique case (q_reg.st)
            ST_FETCH: begin
                if (take) begin
                    q_next.pc = q_reg.pc + 15'h0001;
                    q_next.op = prog_byte;
                    if (prog_byte == OP_PFX_FF || prog_byte == OP_PFX_FE ||
                        prog_byte == OP_PFX_DD || prog_byte == OP_INC_DIR) begin
                        q_next.st = ST_SECOND; // RULE3 RULE7 RULE10
                    end else if (prog_byte == OP_IRQ_RET) begin
                        q_next.st = ST_IRET2; // RULE16
                    end else if ((prog_byte & OP_R_MASK) == OP_INC_REG) begin
                        sum4 = {1'b0, q_reg.regs[prog_byte[2:0]]} + 5'h01; // RULE8 RULE10
                        q_next.regs[prog_byte[2:0]] = sum4[3:0];
                        if (sum4[4]) q_next.st = ST_SKIP;
                    end else if ((prog_byte & OP_RR_MASK) == OP_INC_PAIR) begin
                        a    = {q_reg.regs[{prog_byte[2:1], 1'b1}], q_reg.regs[{prog_byte[2:1], 1'b0}]};
                        sum8 = {1'b0, a} + 9'h001; // RULE8 RULE10
                        {q_next.regs[{prog_byte[2:1], 1'b1}], q_next.regs[{prog_byte[2:1], 1'b0}]} = sum8[7:0];
                        if (sum8[8]) q_next.st = ST_SKIP;
                    end else if (len != LEN_ONE) begin
                        q_next.cnt = len - LEN_ONE;
                        q_next.st  = ST_DRAIN;
                    end
                end
            end
            ST_SECOND: begin
                if (take) begin
                    q_next.pc = q_reg.pc + 15'h0001;
                    q_next.st = ST_FETCH;
                    if (q_reg.op == OP_PFX_FF && prog_byte == OP_IRQ_ON2) begin
                        q_next.prio[GIE_BIT] = 1'b1; // RULE1 RULE3
                    end else if (q_reg.op == OP_PFX_FE && prog_byte == OP_IRQ_OFF2) begin
                        q_next.prio[GIE_BIT] = 1'b0; // RULE17
                    end else if (q_reg.op == OP_PFX_FF && prog_byte == OP_HALT2) begin
                        q_next.power[IDLE_BIT] = 1'b1; // RULE4 RULE7
                    end else if (q_reg.op == OP_INC_DIR || (q_reg.op == OP_PFX_DD && prog_byte == OP_INC_PTR2)) begin
                        a    = (q_reg.op == OP_INC_DIR) ? prog_byte : ptr; // RULE11
                        sum4 = {1'b0, q_reg.mem[a]} + 5'h01; // RULE8 RULE9
                        q_next.mem[a] = sum4[3:0];
                        if (sum4[4]) q_next.st = ST_SKIP;
                    end
                end
            end
            ST_SKIP: begin
                if (take) begin
                    q_next.pc = q_reg.pc + 15'h0001; // RULE18
                    if (len == LEN_ONE) begin
                        q_next.st = ST_FETCH;
                    end else begin
                        q_next.cnt = len - LEN_ONE;
                        q_next.st  = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                if (take) begin
                    q_next.pc  = q_reg.pc + 15'h0001;
                    q_next.cnt = q_reg.cnt - 2'h1;
                    if (q_reg.cnt == 2'h1) q_next.st = ST_FETCH;
                end
            end
            ST_IRET2: q_next.st = ST_IRET3; // RULE16
            ST_IRET3: begin
                // pop the six-nibble frame upward from sp
                q_next.pc    = {1'b0, q_reg.mem[q_reg.sp + 8'h01][1:0], q_reg.mem[q_reg.sp],
                                q_reg.mem[q_reg.sp + 8'h03], q_reg.mem[q_reg.sp + 8'h02]}; // RULE12 RULE14 RULE15
                {q_next.isl, q_next.mbank, q_next.rbank} = q_reg.mem[q_reg.sp + 8'h04]; // RULE15
                {q_next.carry, q_next.sc}            = q_reg.mem[q_reg.sp + 8'h05]; // RULE12
                q_next.sp    = q_reg.sp + FRAME_LEN; // RULE12
                q_next.st    = ST_FETCH; // RULE13
            end
        endcase
        q_next.prog_ready = (q_next.st == ST_FETCH || q_next.st == ST_SECOND ||
                             q_next.st == ST_SKIP || q_next.st == ST_DRAIN) &
                            ~q_next.power[IDLE_BIT] & // RULE4
                            ~((q_next.st == ST_FETCH) & q_next.prio[GIE_BIT] & q_next.irq_s & ~q_next.irq_busy);
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg      <= '0;
            q_reg.prio  <= RST_PRIO;
            q_reg.power <= RST_POWER;
            q_reg.sp   <= RST_SP;
            q_reg.pc   <= RST_PC;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    // outputs straight from flops
    assign prog_ready  = q_reg.prog_ready;
    assign fetch_addr  = q_reg.pc;
    assign irq_ack     = q_reg.irq_ack;
    assign core_idle   = q_reg.power[IDLE_BIT];
    assign irq_enabled = q_reg.prio[GIE_BIT];
    assign pready      = q_reg.pready;
    assign prdata      = q_reg.prdata;
    assign pslverr     = q_reg.pslverr;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    irq_on_sets_a: assert property (ce && take && q_reg.st == ST_SECOND && q_reg.op == OP_PFX_FF && // RULE1
        prog_byte == OP_IRQ_ON2 |=> q_reg.prio[GIE_BIT]) else $error("global enable not set");
    irq_off_clears_a: assert property (ce && take && q_reg.st == ST_SECOND && q_reg.op == OP_PFX_FE && // RULE17
        prog_byte == OP_IRQ_OFF2 |=> !q_reg.prio[GIE_BIT]) else $error("global enable not cleared");
    halt_sets_a: assert property (ce && take && q_reg.st == ST_SECOND && q_reg.op == OP_PFX_FF && // RULE4
        prog_byte == OP_HALT2 |=> q_reg.power[IDLE_BIT] && !q_reg.prog_ready) else $error("halt not engaged");
    ack_needs_gie_a: assert property ($rose(q_reg.irq_ack) |-> $past(q_reg.prio[GIE_BIT]) && // RULE2
        $past(q_reg.st) == ST_FETCH) else $error("interrupt served while disabled");
    tick_runs_a: assert property (ce |=> q_reg.tick == $past(q_reg.tick) + 32'h0000_0001) // RULE5
        else $error("peripheral tick stalled");
    interrupt_return_instr_frame_a: assert property (ce && take && q_reg.st == ST_FETCH && prog_byte == OP_IRQ_RET ##1 ce [*2] // RULE12
        |=> q_reg.sp == $past(q_reg.sp) + FRAME_LEN && !q_reg.pc[14] && q_reg.st == ST_FETCH)
        else $error("interrupt return frame wrong");
    interrupt_return_instr_hold_a: assert property (q_reg.st == ST_IRET2 || q_reg.st == ST_IRET3 |-> // RULE13
        !q_reg.prog_ready && !q_reg.irq_ack) else $error("fetch or service during return");
    carry_kept_a: assert property (ce && q_reg.st != ST_IRET3 && !(apb_acc && pwrite && paddr == OFS_STATUS) // RULE9
        |=> $stable(q_reg.carry)) else $error("carry changed");
    wrap_skip_a: assert property (ce && take && q_reg.st == ST_FETCH && // RULE8
        (prog_byte & OP_R_MASK) == OP_INC_REG && q_reg.regs[prog_byte[2:0]] == 4'hf
        |=> q_reg.st == ST_SKIP && q_reg.regs[$past(prog_byte[2:0])] == 4'h0) else $error("wrap skip missed");

    ei_seen_c:   cover property (q_reg.st == ST_SECOND && take && prog_byte == OP_IRQ_ON2);
    skip_seen_c: cover property (q_reg.st == ST_SKIP && take);
    interrupt_return_instr_seen_c: cover property (q_reg.st == ST_IRET3 && ce);
    ack_seen_c:  cover property ($rose(q_reg.irq_ack));
endmodule : cio_core

/* File: design/cio_pkg.sv */
// Overview of operation
// RULE1: enable-interrupts instruction sets global enable, bit 3 of priority register.
// RULE2: with global enable set, pending enabled interrupts are serviced, including earlier ones.
// RULE3: enable-interrupts is bytes FF then B2, taking 2 cycles.
// RULE4: core-halt sets power control bit 2, stopping core while oscillator runs.
// RULE5: peripherals keep running while core is halted.
// RULE6: software places at least three no-operations after every core-halt.
// RULE7: core-halt is bytes FF then A3, taking 2 cycles.
// RULE8: increment-and-skip adds one with wrap; carry out skips next instruction.
// RULE9: increment-and-skip never changes the carry flag.
// RULE10: register and pair forms take 1+S cycles; memory forms 2+S.
// RULE11: direct-memory form is byte CA followed by 8-bit address.
// RULE12: interrupt-return pops PC, adds six to SP, restores status and banks.
// RULE13: pending interrupt is serviced only after interrupt-return finishes.
// RULE14: return address bit 14 is loaded as zero.
// RULE15: frame at SP+0..5 holds PC11-8, PC13-12, PC3-0, PC7-4, levels/banks, carry/skip.
// RULE16: interrupt-return is single byte D5, taking 3 cycles.
// RULE17: disable-interrupts clears global enable; latches still set but unserviced.
// RULE18: skipped instruction is fetched and discarded, costing its own cycles.
package cio_pkg;
    // ****************************************************
    // opcodes
    // ****************************************************
    localparam logic [7:0] OP_PFX_FF   = 8'hff;
    localparam logic [7:0] OP_PFX_FE   = 8'hfe;
    localparam logic [7:0] OP_PFX_DD   = 8'hdd;
    localparam logic [7:0] OP_IRQ_ON2  = 8'hb2;
    localparam logic [7:0] OP_IRQ_OFF2 = 8'hb2;
    localparam logic [7:0] OP_HALT2    = 8'ha3;
    localparam logic [7:0] OP_INC_DIR  = 8'hca;
    localparam logic [7:0] OP_INC_PTR2 = 8'h62;
    localparam logic [7:0] OP_IRQ_RET  = 8'hd5;
    localparam logic [7:0] OP_INC_REG  = 8'h58;
    localparam logic [7:0] OP_R_MASK   = 8'hf8;
    localparam logic [7:0] OP_INC_PAIR = 8'h80;
    localparam logic [7:0] OP_RR_MASK  = 8'hf9;
    localparam logic [7:0] OP_JP       = 8'hdb;
    localparam logic [7:0] OP_PFX_D9   = 8'hd9;
    localparam logic [7:0] OP_PFX_DC   = 8'hdc;
    localparam logic [7:0] OP_JPS      = 8'h90;
    localparam logic [7:0] OP_JPS_MASK = 8'hf0;
    // ****************************************************
    // field positions and constants
    // ****************************************************
    localparam int         GIE_BIT     = 3;
    localparam int         IDLE_BIT    = 2;
    localparam logic [1:0] PTR_PAIR    = 2'h2;
    localparam logic [7:0] FRAME_LEN   = 8'h06;
    localparam logic [1:0] LEN_ONE     = 2'h1;
    localparam logic [1:0] LEN_TWO     = 2'h2;
    localparam logic [1:0] LEN_THREE   = 2'h3;
    // ****************************************************
    // register offsets and reset values
    // ****************************************************
    localparam logic [7:0] OFS_PRIO    = 8'h00;
    localparam logic [7:0] OFS_POWER   = 8'h04;
    localparam logic [7:0] OFS_CORE    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_MADDR   = 8'h10;
    localparam logic [7:0] OFS_MDATA   = 8'h14;
    localparam logic [7:0] OFS_REGS    = 8'h18;
    localparam logic [7:0] OFS_TICK    = 8'h1c;
    localparam logic [3:0] RST_PRIO    = 4'h0;
    localparam logic [3:0] RST_POWER   = 4'h0;
    localparam logic [7:0] RST_SP      = 8'h00;
    localparam logic [14:0] RST_PC     = 15'h0000;
    typedef enum logic [2:0] {ST_FETCH, ST_SECOND, ST_IRET2, ST_IRET3, ST_SKIP, ST_DRAIN} cio_state_e;
endpackage : cio_pkg

/* File: design/cio_len.sv */
`timescale 1ns/100ps
// instruction length from its first byte
module cio_len
    import cio_pkg::*;
(
    // opcode in, length out
    input  wire logic [7:0] first_byte,
    output logic      [1:0] len
);
    // ****************************************************
    // length lookup
    // ****************************************************
    always_comb begin
        if (first_byte == OP_JP) begin
            len = LEN_THREE;
        end else if (first_byte == OP_PFX_FF || first_byte == OP_PFX_FE || first_byte == OP_PFX_DD ||
                     first_byte == OP_PFX_DC || first_byte == OP_PFX_D9 || first_byte == OP_INC_DIR ||
                     (first_byte & OP_JPS_MASK) == OP_JPS) begin
            len = LEN_TWO;
        end else begin
            len = LEN_ONE;
        end
    end
endmodule : cio_len

/* File: tb/cio_core_bench.sv */
`timescale 1ns/100ps
module cpu_intr_idle_incskip_ops_bench;
    import cio_pkg::*;
    // ****************************************************
    // signals
    // ****************************************************
    logic        clk, rst_n, ce, prog_valid, irq_req, psel, penable, pwrite;
    logic [7:0]  prog_byte, paddr, a, v;
    logic [31:0] pwdata, prdata, t1, t2;
    logic        prog_ready, irq_ack, core_idle, irq_enabled, pready, pslverr;
    logic [14:0] fetch_addr;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [23:0] frame;
    int          n_mismatch, total_checks, n_ack, r, n;

    cio_core i_cio_core (.clk(clk), .rst_n(rst_n), .ce(ce), .prog_valid(prog_valid), .prog_byte(prog_byte),
        .prog_ready(prog_ready), .fetch_addr(fetch_addr), .irq_req(irq_req), .irq_ack(irq_ack),
        .core_idle(core_idle), .irq_enabled(irq_enabled), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ****************************************************
    // clock, compare and report
    // ****************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic cmp_word(input string what, input logic [32:0] x, input logic [32:0] got);
        total_checks++;
        if (got !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, x, got);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string what, input logic x, input logic got);
        total_checks++;
        if (got !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, x, got);
        end
    endtask : cmp_bit

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // watchdog against a hung handshake
    initial begin
        #(8 * 30000);
        n_mismatch++;
        complete_run();
    end

    // read results taken off the queue as they appear
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            if (e[33])
                cmp_word("apb read", e[32:0], {pslverr, prdata});
        end
        if (irq_ack === 1'b1)
            n_ack <= n_ack + 1;
    end

    // ****************************************************
    // drivers
    // ****************************************************
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, ad, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic err = 1'b0);
        logic [31:0] q;
        exp_q.push_back({1'b1, err, x});
        apb(1'b0, ad, 32'h0000_0000, q);
    endtask : rd

    task automatic rd_any(input logic [7:0] ad, output logic [31:0] q);
        exp_q.push_back(34'h0);
        apb(1'b0, ad, 32'h0000_0000, q);
    endtask : rd_any

    task automatic mem_wr(input logic [7:0] ad, input logic [3:0] d);
        wr(OFS_MADDR, {24'h0, ad});
        wr(OFS_MDATA, {28'h0, d});
    endtask : mem_wr

    task automatic mem_rd(input logic [7:0] ad, input logic [3:0] d);
        wr(OFS_MADDR, {24'h0, ad});
        rd(OFS_MDATA, {28'h0, d});
    endtask : mem_rd

    // one program byte, held until taken
    task automatic send(input logic [7:0] b);
        prog_valid <= 1'b1;
        prog_byte  <= b;
        do begin
            @(posedge clk);
        end while (prog_ready !== 1'b1);
    endtask : send

    // increment, then an irq-on pair that a carry must discard
    task automatic run_increment_skip_instr(input logic [7:0] op0, input logic [7:0] op1, input logic two, input logic skip);
        send(op0);
        if (two)
            send(op1);
        send(OP_PFX_FF);
        send(OP_IRQ_ON2);
        prog_valid <= 1'b0;
        rd(OFS_PRIO, skip ? 32'h0 : 32'h8);
        cmp_bit("irq enable after increment", !skip, irq_enabled);
        if (!skip) begin
            send(OP_PFX_FE);
            send(OP_IRQ_OFF2);
            prog_valid <= 1'b0;
            rd(OFS_PRIO, 32'h0);
        end
    endtask : run_increment_skip_instr

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        {rst_n, prog_valid, irq_req, psel, penable, pwrite} = 6'h00;
        {prog_byte, paddr, pwdata} = 48'h0;
        ce = 1'b1;
        void'($urandom(32'h33f9));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_PRIO, 32'h0);
        rd(OFS_POWER, 32'h0);
        rd(OFS_CORE, 32'h0);
        rd(8'h20, 32'h0, 1'b1);
        // register increment, with and without carry
        wr(OFS_STATUS, 32'h80);
        r = $urandom_range(7);
        for (n = 0; n < 2; n++) begin
            wr(OFS_REGS, (n ? 32'h7 : 32'hf) << (4 * r));
            run_increment_skip_instr(OP_INC_REG | 8'(r), 8'h00, 1'b0, n == 0);
            rd(OFS_REGS, (n ? 32'h8 : 32'h0) << (4 * r));
        end
        // register pair increment wrapping to zero
        r = $urandom_range(3);
        wr(OFS_REGS, 32'hff << (8 * r));
        run_increment_skip_instr(OP_INC_PAIR | 8'(r << 1), 8'h00, 1'b0, 1'b1);
        rd(OFS_REGS, 32'h0);
        // direct memory increment
        a = 8'($urandom);
        for (n = 0; n < 2; n++) begin
            mem_wr(a, n ? 4'hf : 4'he);
            run_increment_skip_instr(OP_INC_DIR, a, 1'b1, n == 1);
            mem_rd(a, n ? 4'h0 : 4'hf);
        end
        // indirect increment through the pointer pair
        v = 8'($urandom);
        wr(OFS_REGS, {8'h0, v, 16'h0});
        mem_wr(v, 4'hf);
        run_increment_skip_instr(OP_PFX_DD, OP_INC_PTR2, 1'b1, 1'b1);
        mem_rd(v, 4'h0);
        rd(OFS_STATUS, 32'h80);
        // halt, peripheral keeps counting, wake by request
        send(OP_PFX_FF);
        send(OP_HALT2);
        prog_valid <= 1'b0;
        rd(OFS_POWER, 32'h4);
        cmp_bit("core idle", 1'b1, core_idle);
        rd_any(OFS_TICK, t1);
        rd_any(OFS_TICK, t2);
        cmp_bit("tick runs while halted", 1'b1, t2 != t1);
        cmp_bit("no fetch while halted", 1'b0, prog_ready);
        irq_req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (core_idle !== 1'b0 && n < 20);
        repeat (3) send(8'h00);
        prog_valid <= 1'b0;
        cmp_bit("no service while disabled", 1'b1, n_ack == 0);
        send(OP_PFX_FF);
        send(OP_IRQ_ON2);
        prog_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (n_ack == 0 && n < 20);
        cmp_bit("pending request served", 1'b1, n_ack == 1);
        irq_req <= 1'b0;
        repeat (4) @(posedge clk);
        // clock enable low freezes the peripheral counter too
        rd_any(OFS_TICK, t1);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rd_any(OFS_TICK, t2);
        cmp_word("tick frozen while disabled", 33'(t1) + 33'h0_0000_0004, {1'b0, t2});
        // interrupt return from a six-nibble frame
        frame = 24'h9a_4523;
        wr(OFS_CORE, 32'h00fa_4100);
        for (n = 0; n < 6; n++)
            mem_wr(8'hfa + 8'(n), frame[4 * n +: 4]);
        send(OP_IRQ_RET);
        prog_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prog_ready !== 1'b1 && n < 20);
        cmp_word("return cycles", 33'd3, 33'(n));
        cmp_word("return address", 33'h2345, {18'h0, fetch_addr});
        rd(OFS_CORE, 32'h0000_2345);
        rd(OFS_STATUS, 32'h9a);
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule : cpu_intr_idle_incskip_ops_bench
